// file: rtl/sbbo_pkg.sv
// Summary of operation
// [RL1] skip next word when register bit clear
// [RL2] skip next word when register bit set
// [RL3] skip next word on io bit state
// [RL4] indexed status flag branch, pc plus offset plus one
// [RL5] carry branches: set/lower, clear/same-or-higher
// [RL6] signed branches on negative xor overflow
// [RL7] half-carry branches, set or cleared form
// [RL8] transfer flag branches, set or cleared form
// [RL9] overflow branches, set or cleared form
// [RL10] interrupt enable branches, enabled or disabled
// [RL11] set one io bit, two cycles
// [RL12] clear one io bit, two cycles
// [RL13] logical shifts update zero carry negative overflow
`default_nettype none
package sbbo_pkg;
    localparam int unsigned PC_W_DEF = 16;
    localparam int unsigned OFS_W = 7;
    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    // cycle counts
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    // program counter steps
    localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
    localparam logic [1:0] STEP_SKIP_TWO = 2'h3;
    localparam logic [1:0] STEP_BRANCH = 2'h1;
    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_IO_ADDR = 6'h00;
    localparam logic [1:0] RST_CNT = 2'h0;

    typedef enum logic [4:0] {
        op_none,
        op_skip_if_reg_bit_clear,
        op_skip_if_reg_bit_set,
        op_skip_if_io_bit_clear,
        op_skip_if_io_bit_set,
        op_branch_on_flag_set,
        op_branch_on_flag_clear,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_set,
        op_branch_carry_clear,
        op_branch_same_or_higher,
        op_branch_lower,
        op_branch_minus,
        op_branch_plus,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_halfcarry_set,
        op_branch_halfcarry_clear,
        op_branch_xfer_flag_set,
        op_branch_xfer_flag_clear,
        op_branch_overflow_set,
        op_branch_overflow_clear,
        op_branch_irq_enabled,
        op_branch_irq_disabled,
        op_set_io_bit,
        op_clear_io_bit,
        op_shift_left_logical,
        op_shift_right_logical
    } sbbo_op_e;

    typedef enum logic {
        st_idle,
        st_busy
    } sbbo_state_e;
endpackage : sbbo_pkg
`default_nettype wire

// file: rtl/sbbo_exec.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module sbbo_exec #(
    parameter int unsigned PC_W = sbbo_pkg::PC_W_DEF
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic op_valid,
    input wire sbbo_pkg::sbbo_op_e op_code,
    input wire logic [PC_W-1:0] pc,
    input wire logic [7:0] reg_value,
    input wire logic [2:0] bit_sel,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_rdata,
    input wire logic next_is_two_word,
    input wire logic [sbbo_pkg::OFS_W-1:0] branch_offset,
    input wire logic [7:0] flags_in,
    output logic busy,
    output logic done,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic io_we,
    output logic [5:0] io_waddr,
    output logic [7:0] io_wdata,
    output logic reg_we,
    output logic [7:0] reg_wdata,
    output logic flags_we,
    output logic [7:0] flags_out
);
    import sbbo_pkg::*;

    // {is_branch, taken}
    function automatic logic [1:0] branch_eval(input sbbo_op_e op, input logic [7:0] f,
                                               input logic [2:0] s);
        logic nv;
        nv = f[FLAG_N] ^ f[FLAG_V];
        case (op)
            op_branch_on_flag_set: branch_eval = {1'b1, f[s]}; // RL4
            op_branch_on_flag_clear: branch_eval = {1'b1, ~f[s]}; // RL4
            op_branch_equal: branch_eval = {1'b1, f[FLAG_Z]};
            op_branch_not_equal: branch_eval = {1'b1, ~f[FLAG_Z]};
            op_branch_carry_set: branch_eval = {1'b1, f[FLAG_C]}; // RL5
            op_branch_lower: branch_eval = {1'b1, f[FLAG_C]}; // RL5
            op_branch_carry_clear: branch_eval = {1'b1, ~f[FLAG_C]}; // RL5
            op_branch_same_or_higher: branch_eval = {1'b1, ~f[FLAG_C]}; // RL5
            op_branch_minus: branch_eval = {1'b1, f[FLAG_N]};
            op_branch_plus: branch_eval = {1'b1, ~f[FLAG_N]};
            op_branch_signed_ge: branch_eval = {1'b1, ~nv}; // RL6
            op_branch_signed_lt: branch_eval = {1'b1, nv}; // RL6
            op_branch_halfcarry_set: branch_eval = {1'b1, f[FLAG_H]}; // RL7
            op_branch_halfcarry_clear: branch_eval = {1'b1, ~f[FLAG_H]}; // RL7
            op_branch_xfer_flag_set: branch_eval = {1'b1, f[FLAG_T]}; // RL8
            op_branch_xfer_flag_clear: branch_eval = {1'b1, ~f[FLAG_T]}; // RL8
            op_branch_overflow_set: branch_eval = {1'b1, f[FLAG_V]}; // RL9
            op_branch_overflow_clear: branch_eval = {1'b1, ~f[FLAG_V]}; // RL9
            op_branch_irq_enabled: branch_eval = {1'b1, f[FLAG_I]}; // RL10
            op_branch_irq_disabled: branch_eval = {1'b1, ~f[FLAG_I]}; // RL10
            default: branch_eval = 2'h0;
        endcase
    endfunction : branch_eval

    // {is_skip, taken}
    function automatic logic [1:0] skip_eval(input sbbo_op_e op, input logic [7:0] rv,
                                             input logic [7:0] iv, input logic [2:0] b);
        case (op)
            op_skip_if_reg_bit_clear: skip_eval = {1'b1, ~rv[b]}; // RL1
            op_skip_if_reg_bit_set: skip_eval = {1'b1, rv[b]}; // RL2
            op_skip_if_io_bit_clear: skip_eval = {1'b1, ~iv[b]}; // RL3
            op_skip_if_io_bit_set: skip_eval = {1'b1, iv[b]}; // RL3
            default: skip_eval = 2'h0;
        endcase
    endfunction : skip_eval

    sbbo_state_e state_reg;
    logic [1:0] cnt_reg;
    logic accept;
    logic finish;
    logic [1:0] br;
    logic [1:0] sk;
    logic [PC_W-1:0] ofs_ext;
    logic [1:0] c_cycles;
    logic c_pc_load;
    logic [PC_W-1:0] c_pc;
    logic c_io_we;
    logic [7:0] c_io_data;
    logic c_reg_we;
    logic [7:0] c_reg_data;
    logic c_flags_we;
    logic [7:0] c_flags;
    logic h_pc_load_reg;
    logic [PC_W-1:0] h_pc_reg;
    logic h_io_we_reg;
    logic [5:0] h_io_addr_reg;
    logic [7:0] h_io_data_reg;

    assign busy = (state_reg == st_busy);
    assign accept = op_valid && (state_reg == st_idle);
    assign finish = (accept && (c_cycles == CYC_ONE)) || (busy && (cnt_reg == CYC_ONE));
    assign br = branch_eval(op_code, flags_in, bit_sel);
    assign sk = skip_eval(op_code, reg_value, io_rdata, bit_sel);
    assign ofs_ext = {{(PC_W - OFS_W){branch_offset[OFS_W-1]}}, branch_offset};

    // decision for the instruction presented now
    always_comb begin
        c_cycles = CYC_ONE;
        c_pc_load = 1'b0;
        c_pc = pc;
        c_io_we = 1'b0;
        c_io_data = io_rdata;
        c_reg_we = 1'b0;
        c_reg_data = reg_value;
        c_flags_we = 1'b0;
        c_flags = flags_in;
        if (br[1]) begin
            // flags never touched by branches
            c_pc_load = br[0];
            c_pc = pc + ofs_ext + PC_W'(STEP_BRANCH); // RL4
            c_cycles = br[0] ? CYC_TWO : CYC_ONE;
        end else if (sk[1]) begin
            // skip past a one or two word follower
            c_pc_load = sk[0];
            c_pc = pc + PC_W'(next_is_two_word ? STEP_SKIP_TWO : STEP_SKIP_ONE); // RL1
            c_cycles = sk[0] ? (next_is_two_word ? CYC_THREE : CYC_TWO) : CYC_ONE; // RL2
        end else begin
            case (op_code)
                op_set_io_bit: begin
                    c_io_we = 1'b1;
                    c_io_data = io_rdata | (8'h01 << bit_sel); // RL11
                    c_cycles = CYC_TWO;
                end
                op_clear_io_bit: begin
                    c_io_we = 1'b1;
                    c_io_data = io_rdata & ~(8'h01 << bit_sel); // RL12
                    c_cycles = CYC_TWO;
                end
                op_shift_left_logical: begin
                    c_reg_we = 1'b1;
                    c_reg_data = {reg_value[6:0], 1'b0}; // RL13
                    c_flags_we = 1'b1;
                    c_flags[FLAG_C] = reg_value[7];
                    c_flags[FLAG_N] = reg_value[6];
                    c_flags[FLAG_V] = reg_value[6] ^ reg_value[7];
                    c_flags[FLAG_Z] = (reg_value[6:0] == 7'h00);
                end
                op_shift_right_logical: begin
                    c_reg_we = 1'b1;
                    c_reg_data = {1'b0, reg_value[7:1]}; // RL13
                    c_flags_we = 1'b1;
                    c_flags[FLAG_C] = reg_value[0];
                    c_flags[FLAG_N] = 1'b0;
                    c_flags[FLAG_V] = reg_value[0];
                    c_flags[FLAG_Z] = (reg_value[7:1] == 7'h00);
                end
                default: begin
                    c_cycles = CYC_ONE;
                end
            endcase
        end
    end

    // sequencing of multi-cycle instructions
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_reg <= st_idle;
            cnt_reg <= RST_CNT;
        end else begin
            case (state_reg)
                st_idle: begin
                    if (accept && (c_cycles != CYC_ONE)) begin
                        state_reg <= st_busy;
                        cnt_reg <= c_cycles - CYC_ONE;
                    end
                end
                st_busy: begin
                    cnt_reg <= cnt_reg - CYC_ONE;
                    if (cnt_reg == CYC_ONE) begin
                        state_reg <= st_idle;
                    end
                end
                default: begin
                    state_reg <= st_idle;
                    cnt_reg <= RST_CNT;
                end
            endcase
        end
    end

    // result held until the last cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            h_pc_load_reg <= 1'b0;
            h_pc_reg <= '0;
            h_io_we_reg <= 1'b0;
            h_io_addr_reg <= RST_IO_ADDR;
            h_io_data_reg <= RST_BYTE;
        end else if (accept) begin
            h_pc_load_reg <= c_pc_load;
            h_pc_reg <= c_pc;
            h_io_we_reg <= c_io_we;
            h_io_addr_reg <= io_addr;
            h_io_data_reg <= c_io_data;
        end
    end

    // completion strobes and data toward the core
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            done <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= '0;
            io_we <= 1'b0;
            io_waddr <= RST_IO_ADDR;
            io_wdata <= RST_BYTE;
            reg_we <= 1'b0;
            reg_wdata <= RST_BYTE;
            flags_we <= 1'b0;
            flags_out <= RST_BYTE;
        end else begin
            done <= finish;
            pc_load <= finish && (busy ? h_pc_load_reg : c_pc_load);
            io_we <= finish && (busy ? h_io_we_reg : c_io_we); // RL11
            reg_we <= finish && !busy && c_reg_we;
            flags_we <= finish && !busy && c_flags_we; // RL13
            if (finish) begin
                pc_value <= busy ? h_pc_reg : c_pc;
                io_waddr <= busy ? h_io_addr_reg : io_addr;
                io_wdata <= busy ? h_io_data_reg : c_io_data; // RL12
                reg_wdata <= c_reg_data;
                flags_out <= c_flags;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    logic [PC_W-1:0] chk_target;
    assign chk_target = pc + {{(PC_W - OFS_W){branch_offset[OFS_W-1]}}, branch_offset} + 1'b1;

    skip_reg_clear_a: assert property (accept && op_code == op_skip_if_reg_bit_clear // RL1
        && !reg_value[bit_sel] && !next_is_two_word |-> ##1 busy ##1
        (done && pc_load && pc_value == $past(pc, 2) + PC_W'(2) && !flags_we))
        else $error("register-bit-clear skip wrong");
    skip_reg_set_a: assert property (accept && op_code == op_skip_if_reg_bit_set // RL2
        && reg_value[bit_sel] && next_is_two_word |-> ##1 busy[*2] ##1
        (done && pc_load && pc_value == $past(pc, 3) + PC_W'(3) && !flags_we))
        else $error("register-bit-set skip wrong");
    skip_io_bit_a: assert property (accept && ((op_code == op_skip_if_io_bit_clear // RL3
        && io_rdata[bit_sel]) || (op_code == op_skip_if_io_bit_set && !io_rdata[bit_sel]))
        |=> done && !pc_load && !busy && !flags_we)
        else $error("io-bit skip taken when it should not");
    flag_branch_a: assert property (accept && op_code == op_branch_on_flag_set // RL4
        && flags_in[bit_sel] |-> ##2
        (done && pc_load && pc_value == $past(chk_target, 2)))
        else $error("indexed flag branch target wrong");
    carry_branch_a: assert property (accept && (op_code == op_branch_same_or_higher // RL5
        || op_code == op_branch_carry_clear) && flags_in[FLAG_C] |=> done && !pc_load)
        else $error("carry branch taken on carry set");
    signed_branch_a: assert property (accept && op_code == op_branch_signed_lt // RL6
        && (flags_in[FLAG_N] ^ flags_in[FLAG_V]) |-> ##1 busy ##1 (done && pc_load))
        else $error("signed less-than branch not taken");
    halfcarry_a: assert property (accept && op_code == op_branch_halfcarry_clear // RL7
        && flags_in[FLAG_H] |=> done && !pc_load && !flags_we)
        else $error("half-carry branch taken wrongly");
    xfer_flag_a: assert property (accept && op_code == op_branch_xfer_flag_set // RL8
        && !flags_in[FLAG_T] |=> done && !pc_load)
        else $error("transfer flag branch taken wrongly");
    overflow_a: assert property (accept && op_code == op_branch_overflow_clear // RL9
        && !flags_in[FLAG_V] |=> busy ##1 (done && pc_load && !flags_we))
        else $error("overflow clear branch not taken");
    irq_branch_a: assert property (accept && op_code == op_branch_irq_disabled // RL10
        && flags_in[FLAG_I] |=> done && !pc_load)
        else $error("irq disabled branch taken with irq on");
    set_io_a: assert property (accept && op_code == op_set_io_bit |=> busy ##1 // RL11
        (done && io_we && !flags_we && io_waddr == $past(io_addr, 2)
        && io_wdata == ($past(io_rdata, 2) | (8'h01 << $past(bit_sel, 2)))))
        else $error("io bit set wrong");
    clear_io_a: assert property (accept && op_code == op_clear_io_bit |=> busy ##1 // RL12
        (done && io_we && !flags_we && io_waddr == $past(io_addr, 2)
        && io_wdata == ($past(io_rdata, 2) & ~(8'h01 << $past(bit_sel, 2)))))
        else $error("io bit clear wrong");
    shift_left_a: assert property (accept && op_code == op_shift_left_logical |=> // RL13
        done && reg_we && flags_we && reg_wdata == {$past(reg_value[6:0]), 1'b0}
        && flags_out[FLAG_C] == $past(reg_value[7]) && flags_out[FLAG_Z] == (reg_wdata == 8'h00))
        else $error("left shift result or flags wrong");

    // counterparts: the other outcome, form or case of the tests above
    skip_clear_not_a: assert property (accept && op_code == op_skip_if_reg_bit_clear // RL1
        && reg_value[bit_sel] |=> done && !pc_load && !busy)
        else $error("register-bit-clear skip taken");
    skip_set_one_a: assert property (accept && op_code == op_skip_if_reg_bit_set // RL2
        && reg_value[bit_sel] && !next_is_two_word |-> ##1 busy ##1
        (done && pc_load && pc_value == $past(pc, 2) + PC_W'(2)))
        else $error("register-bit-set short skip wrong");
    skip_io_taken_a: assert property (accept && op_code == op_skip_if_io_bit_set // RL3
        && io_rdata[bit_sel] && !next_is_two_word |-> ##1 busy ##1
        (done && pc_load && pc_value == $past(pc, 2) + PC_W'(2)))
        else $error("io-bit-set skip wrong");
    skip_untaken_a: assert property (accept && sk[1] && !sk[0] |=> done && !busy // RL3
        && !flags_we && !reg_we && !io_we)
        else $error("untaken skip wrote state");
    flag_clear_a: assert property (accept && op_code == op_branch_on_flag_clear // RL4
        && !flags_in[bit_sel] |-> ##2 (done && pc_load && pc_value == $past(chk_target, 2)))
        else $error("flag-clear branch wrong");
    carry_taken_a: assert property (accept && (op_code == op_branch_carry_set // RL5
        || op_code == op_branch_lower) && flags_in[FLAG_C] |=> busy ##1
        (done && pc_load && pc_value == $past(chk_target, 2)))
        else $error("carry set branch wrong");
    signed_ge_a: assert property (accept && op_code == op_branch_signed_ge // RL6
        && (flags_in[FLAG_N] ^ flags_in[FLAG_V]) |=> done && !pc_load)
        else $error("signed ge branch taken");
    halfcarry_taken_a: assert property (accept && op_code == op_branch_halfcarry_set // RL7
        && flags_in[FLAG_H] |=> busy ##1 (done && pc_load && !flags_we))
        else $error("half-carry set branch not taken");
    xfer_taken_a: assert property (accept && op_code == op_branch_xfer_flag_clear // RL8
        && !flags_in[FLAG_T] |=> busy ##1 (done && pc_load))
        else $error("transfer flag clear branch not taken");
    branch_quiet_a: assert property (accept && br[1] && !br[0] |=> done && !busy // RL9
        && !io_we && !reg_we && !flags_we)
        else $error("untaken branch wrote state");
    irq_taken_a: assert property (accept && op_code == op_branch_irq_enabled // RL10
        && flags_in[FLAG_I] |=> busy ##1 (done && pc_load && pc_value == $past(chk_target, 2)))
        else $error("irq enabled branch wrong");
    refuse_busy_a: assert property (busy && op_valid && cnt_reg == CYC_ONE // RL11
        |=> !busy && done)
        else $error("instruction taken while busy");
    shift_right_a: assert property (accept && op_code == op_shift_right_logical |=> // RL13
        done && reg_we && reg_wdata == {1'b0, $past(reg_value[7:1])} && !flags_out[FLAG_N]
        && flags_out[FLAG_C] == $past(reg_value[0]) && flags_out[FLAG_V] == flags_out[FLAG_C])
        else $error("right shift result or flags wrong");

    skip_two_word_c: cover property (accept && sk[1] && sk[0] && next_is_two_word ##3 done);
    branch_taken_c: cover property (accept && br[1] && br[0] ##2 (done && pc_load));
    io_back_to_back_c: cover property (accept && op_code == op_set_io_bit ##2
        (accept && op_code == op_clear_io_bit));
    io_clear_c: cover property (accept && op_code == op_clear_io_bit ##2 (done && io_we));
    refused_op_c: cover property (busy && op_valid ##1 done);
endmodule : sbbo_exec
`default_nettype wire

// file: rtl/sbbo_fix_note.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: sim/sbbo_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module sbbo_core_model (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [5:0] io_addr,
    output logic [7:0] io_rdata,
    input wire logic io_we,
    input wire logic [5:0] io_waddr,
    input wire logic [7:0] io_wdata
);
    logic [7:0] io_mem_reg [64];
    // io space of the core, written only by the block
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < 64; i++) io_mem_reg[i] <= 8'h00;
        end else if (io_we) begin
            io_mem_reg[io_waddr] <= io_wdata;
        end
    end
    assign io_rdata = io_mem_reg[io_addr];
endmodule : sbbo_core_model
`default_nettype wire

// file: sim/skip_branch_bit_ops_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module skip_branch_bit_ops_tb;
    import sbbo_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic op_valid = 1'b0;
    sbbo_op_e op_code = op_none;
    logic [15:0] pc = 16'h0000;
    logic [7:0] reg_value = 8'h00;
    logic [2:0] bit_sel = 3'h0;
    logic [5:0] io_addr = 6'h00;
    logic next_is_two_word = 1'b0;
    logic [6:0] branch_offset = 7'h00;
    logic [7:0] flags_in = 8'h00;
    logic busy, done, pc_load, io_we, reg_we, flags_we;
    logic [15:0] pc_value;
    logic [5:0] io_waddr;
    logic [7:0] io_rdata, io_wdata, reg_wdata, flags_out;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    sbbo_exec #(.PC_W(16)) dut_u (.clk_sys(clk_sys), .srst(srst), .op_valid(op_valid),
        .op_code(op_code), .pc(pc), .reg_value(reg_value), .bit_sel(bit_sel),
        .io_addr(io_addr), .io_rdata(io_rdata), .next_is_two_word(next_is_two_word),
        .branch_offset(branch_offset), .flags_in(flags_in), .busy(busy), .done(done),
        .pc_load(pc_load), .pc_value(pc_value), .io_we(io_we), .io_waddr(io_waddr),
        .io_wdata(io_wdata), .reg_we(reg_we), .reg_wdata(reg_wdata), .flags_we(flags_we),
        .flags_out(flags_out));
    sbbo_core_model core_u (.clk_sys(clk_sys), .srst(srst), .io_addr(io_addr),
        .io_rdata(io_rdata), .io_we(io_we), .io_waddr(io_waddr), .io_wdata(io_wdata));

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test;
        end
    end

    task automatic stop_test;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    // one instruction, then cycle count, pc load and write strobes
    task automatic run_op(input sbbo_op_e op, input logic [15:0] p, input logic [7:0] rv,
        input logic [2:0] b, input logic [5:0] a, input logic tw, input logic [6:0] k,
        input logic [7:0] f, input int ncyc, input logic ld, input logic [15:0] npc,
        input logic [2:0] we);
        int n;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= op;
        pc <= p;
        reg_value <= rv;
        bit_sel <= b;
        io_addr <= a;
        next_is_two_word <= tw;
        branch_offset <= k;
        flags_in <= f;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
        n = 1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK(n, ncyc)
        `CHK(pc_load, ld)
        if (ld) `CHK(pc_value, npc)
        `CHK({io_we, reg_we, flags_we}, we)
    endtask : run_op

    task automatic br(input sbbo_op_e op, input logic [2:0] s, input logic [7:0] f,
        input logic tk);
        run_op(op, 16'h0100, 8'h00, s, 6'h00, 1'b0, 7'h05, f, tk ? 2 : 1, tk, 16'h0106, 3'h0);
    endtask : br

    task automatic sk(input sbbo_op_e op, input logic [7:0] rv, input logic [2:0] b,
        input logic [5:0] a, input logic tw, input logic tk);
        run_op(op, 16'h0200, rv, b, a, tw, 7'h7f, 8'hff, !tk ? 1 : (tw ? 3 : 2), tk,
            tw ? 16'h0203 : 16'h0202, 3'h0);
    endtask : sk

    task automatic io_op(input sbbo_op_e op, input logic [5:0] a, input logic [2:0] b,
        input logic [7:0] d);
        run_op(op, 16'h0300, 8'hff, b, a, 1'b1, 7'h00, 8'hff, 2, 1'b0, 16'h0000, 3'h4);
        `CHK(io_waddr, a)
        `CHK(io_wdata, d)
    endtask : io_op

    task automatic sh(input sbbo_op_e op, input logic [7:0] rv, input logic [7:0] f,
        input logic [7:0] r, input logic [7:0] fo);
        run_op(op, 16'h0400, rv, 3'h0, 6'h00, 1'b0, 7'h00, f, 1, 1'b0, 16'h0000, 3'h3);
        `CHK(reg_wdata, r)
        `CHK(flags_out, fo)
    endtask : sh

    task automatic t_branches;
        sbbo_op_e ops [16] = '{op_branch_equal, op_branch_not_equal, op_branch_carry_set,
            op_branch_carry_clear, op_branch_same_or_higher, op_branch_lower, op_branch_minus,
            op_branch_plus, op_branch_halfcarry_set, op_branch_halfcarry_clear,
            op_branch_xfer_flag_set, op_branch_xfer_flag_clear, op_branch_overflow_set,
            op_branch_overflow_clear, op_branch_irq_enabled, op_branch_irq_disabled};
        int pos [16] = '{1, 1, 0, 0, 0, 0, 2, 2, 5, 5, 6, 6, 3, 3, 7, 7};
        logic [15:0] pol = 16'h5565;
        logic [7:0] f;
        for (int s = 0; s < 8; s++) begin
            br(op_branch_on_flag_set, 3'(s), 8'h01 << s, 1'b1);
            br(op_branch_on_flag_set, 3'(s), ~(8'h01 << s), 1'b0);
            br(op_branch_on_flag_clear, 3'(s), 8'h01 << s, 1'b0);
            br(op_branch_on_flag_clear, 3'(s), ~(8'h01 << s), 1'b1);
        end
        // offset wrap and negative offset
        run_op(op_branch_on_flag_set, 16'hfffe, 8'h00, 3'h0, 6'h00, 1'b0, 7'h01, 8'h01, 2,
            1'b1, 16'h0000, 3'h0);
        run_op(op_branch_on_flag_clear, 16'h0100, 8'h00, 3'h7, 6'h00, 1'b0, 7'h40, 8'h7f, 2,
            1'b1, 16'h00c1, 3'h0);
        for (int i = 0; i < 16; i++) begin
            br(ops[i], 3'h0, 8'h01 << pos[i], pol[i]);
            br(ops[i], 3'h0, ~(8'h01 << pos[i]), !pol[i]);
        end
        // signed flag set opposite to n xor v
        for (int nv = 0; nv < 4; nv++) begin
            f = {3'h0, ~(nv[0] ^ nv[1]), nv[1], nv[0], 2'h0};
            br(op_branch_signed_ge, 3'h0, f, !(nv[0] ^ nv[1]));
            br(op_branch_signed_lt, 3'h0, f, nv[0] ^ nv[1]);
        end
    endtask : t_branches

    task automatic t_refused;
        int hits;
        hits = 0;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= op_branch_on_flag_set;
        pc <= 16'h0500;
        bit_sel <= 3'h0;
        flags_in <= 8'h01;
        branch_offset <= 7'h02;
        io_addr <= 6'h15;
        @(posedge clk_sys);
        op_code <= op_set_io_bit;
        #1;
        `CHK(busy, 1'b1)
        @(posedge clk_sys);
        op_valid <= 1'b0;
        #1;
        `CHK(done, 1'b1)
        `CHK(pc_value, 16'h0503)
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            hits += int'(io_we !== 1'b0);
        end
        `CHK(hits, 0)
    endtask : t_refused

    initial begin
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK({busy, done, pc_load, io_we, reg_we, flags_we}, 6'h00)
        @(posedge clk_sys);
        srst <= 1'b0;
        for (int b = 0; b < 8; b++) begin
            sk(op_skip_if_reg_bit_set, 8'h01 << b, 3'(b), 6'h00, b[0], 1'b1);
            sk(op_skip_if_reg_bit_clear, 8'h01 << b, 3'(b), 6'h00, b[0], 1'b0);
            sk(op_skip_if_reg_bit_set, ~(8'h01 << b), 3'(b), 6'h00, b[0], 1'b0);
            sk(op_skip_if_reg_bit_clear, ~(8'h01 << b), 3'(b), 6'h00, !b[0], 1'b1);
        end
        t_branches;
        io_op(op_set_io_bit, 6'h2a, 3'h3, 8'h08);
        io_op(op_set_io_bit, 6'h2a, 3'h7, 8'h88);
        io_op(op_set_io_bit, 6'h3f, 3'h0, 8'h01);
        sk(op_skip_if_io_bit_set, 8'h77, 3'h3, 6'h2a, 1'b1, 1'b1);
        sk(op_skip_if_io_bit_clear, 8'h77, 3'h3, 6'h2a, 1'b0, 1'b0);
        io_op(op_clear_io_bit, 6'h2a, 3'h3, 8'h80);
        io_op(op_clear_io_bit, 6'h2a, 3'h3, 8'h80);
        sk(op_skip_if_io_bit_clear, 8'h08, 3'h3, 6'h2a, 1'b1, 1'b1);
        sk(op_skip_if_io_bit_set, 8'h08, 3'h3, 6'h2a, 1'b0, 1'b0);
        sk(op_skip_if_io_bit_set, 8'h00, 3'h0, 6'h3f, 1'b0, 1'b1);
        sh(op_shift_left_logical, 8'h81, 8'hf0, 8'h02, 8'hf9);
        sh(op_shift_left_logical, 8'h40, 8'h0f, 8'h80, 8'h0c);
        sh(op_shift_left_logical, 8'h00, 8'hff, 8'h00, 8'hf2);
        sh(op_shift_right_logical, 8'h01, 8'h00, 8'h00, 8'h0b);
        sh(op_shift_right_logical, 8'h80, 8'hff, 8'h40, 8'hf0);
        t_refused;
        stop_test;
    end
endmodule : skip_branch_bit_ops_tb
`default_nettype wire
